// ==== amrtc_defs.vh ====
// Register offsets, field positions, reset values and timing figures of the converter control block
`ifndef AMRTC_DEFS_VH
`define AMRTC_DEFS_VH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define AMRTC_ADDR_W 16
`define AMRTC_OFF_CTRL 16'h7f20
`define AMRTC_OFF_MODE 16'h7f21
`define AMRTC_OFF_RLOW 16'h7f22
`define AMRTC_OFF_RHIGH 16'h7f23
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define AMRTC_CTRL_CHAN_HI 7
`define AMRTC_CTRL_CHAN_LO 4
`define AMRTC_CTRL_CMP 3
`define AMRTC_CTRL_START 2
`define AMRTC_CTRL_DONE 1
`define AMRTC_CTRL_IRQEN 0
`define AMRTC_MODE_RESOLUTION_SELECT 6
`define AMRTC_MODE_ADJ 2
`define AMRTC_RLOW_CMPRES 7
`define AMRTC_RLOW_DIVHI 0
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define AMRTC_RST_CTRL 8'h00
`define AMRTC_RST_MODE 8'h00
`define AMRTC_RST_RLOW 8'h00
`define AMRTC_RST_RHIGH 8'h00
// Writable masks; fixed bits read zero
`define AMRTC_MODE_MASK 8'h47
`define AMRTC_RLOW_MASK 8'hf1
// ----------------------------------------------------------------------
// Timing figures in cycle clocks
// ----------------------------------------------------------------------
`define AMRTC_BASE_12 8'h34
`define AMRTC_BASE_8 8'h20
`define AMRTC_BASE_CMP 8'h1c
`define AMRTC_TAIL 8'h02
`define AMRTC_CNT_W 16
`endif

// ==== amrtc_len_calc.v ====
// Conversion length calculator from mode and division code
`default_nettype none
`include "amrtc_defs.vh"
module amrtc_len_calc #(
   parameter CNT_W = `AMRTC_CNT_W
) (
   // Settings
   input wire cmp_mode,
   input wire eight_bit,
   input wire doubled,
   input wire [2:0] div_code,
   // Result
   output wire [CNT_W-1:0] length
);
   reg [7:0] base;
   wire [CNT_W-1:0] scaled;
   wire [CNT_W-1:0] normal;
   always @* begin
      if (cmp_mode) begin
         base = `AMRTC_BASE_CMP;
      end else if (eight_bit) begin
         base = `AMRTC_BASE_8;
      end else begin
         base = `AMRTC_BASE_12;
      end
   end
   // Ratio 1/2^n: clock divided by ratio means base times 2^n
   assign scaled = {{(CNT_W-8){1'b0}}, base} << div_code;
   assign normal = scaled + {{(CNT_W-8){1'b0}}, `AMRTC_TAIL};
   assign length = doubled ? {normal[CNT_W-2:0], 1'b0} : normal;
endmodule
`default_nettype wire

// ==== amrtc_ctrl.v ====
// Converter control: registers, conversion timing, result placement and completion
//
// Decided for this implementation: strobed register access.
`default_nettype none
`include "amrtc_defs.vh"
module amrtc_ctrl #(
   parameter CNT_W = `AMRTC_CNT_W,
   parameter RES_W = 12
) (
   // Clock and reset
   input wire clk,
   input wire sys_rst,
   // Register port
   input wire [`AMRTC_ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // Analogue front end
   input wire [RES_W-1:0] conv_value,
   input wire cmp_ref_below,
   output reg [3:0] input_channel_select,
   output reg comparator_select,
   output reg offset_comp_ctrl,
   output reg conv_busy,
   // Interrupt request
   output wire done_irq
);
   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   localparam ST_IDLE = 2'b01;
   localparam ST_RUN = 2'b10;
   reg [1:0] state;
   reg [7:0] conv_mode_reg;
   reg [7:0] result_low_reg;
   reg [7:0] result_high_reg;
   reg conversion_done_flag;
   reg done_irq_enable;
   reg first_12_pending;
   reg [CNT_W-1:0] count;
   reg run_cmp;
   reg run_eight;
   wire [CNT_W-1:0] length;
   wire wr_ctrl;
   wire wr_mode;
   wire wr_low;
   wire wr_high;
   wire start_wr;
   wire stop_wr;
   wire finish;
   wire resolution_select;
   wire [2:0] div_code;
   wire cmp_now;

   assign wr_ctrl = reg_wr && (reg_addr == `AMRTC_OFF_CTRL);
   assign wr_mode = reg_wr && (reg_addr == `AMRTC_OFF_MODE);
   assign wr_low = reg_wr && (reg_addr == `AMRTC_OFF_RLOW);
   assign wr_high = reg_wr && (reg_addr == `AMRTC_OFF_RHIGH);
   assign resolution_select = conv_mode_reg[`AMRTC_MODE_RESOLUTION_SELECT];
   assign div_code = {result_low_reg[`AMRTC_RLOW_DIVHI], conv_mode_reg[1:0]};
   // A start write may carry a new mode bit; the run must use the value written
   assign cmp_now = wr_ctrl ? reg_wdata[`AMRTC_CTRL_CMP] : comparator_select;
   assign start_wr = wr_ctrl && reg_wdata[`AMRTC_CTRL_START] && (state == ST_IDLE);
   assign stop_wr = wr_ctrl && !reg_wdata[`AMRTC_CTRL_START] && (state == ST_RUN);
   assign finish = (state == ST_RUN) && (count == {{(CNT_W-1){1'b0}}, 1'b1}) && !stop_wr;
   assign done_irq = done_irq_enable && conversion_done_flag;

   // ----------------------------------------------------------------------
   // Length of the conversion about to start
   // ----------------------------------------------------------------------
   amrtc_len_calc #(
      .CNT_W(CNT_W)
   ) amrtc_len_calc_inst (
      .cmp_mode(cmp_now),
      .eight_bit(resolution_select),
      .doubled(!cmp_now && !resolution_select && first_12_pending),
      .div_code(div_code),
      .length(length)
   );

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         count <= {CNT_W{1'b0}};
         conv_busy <= 1'b0;
         run_cmp <= 1'b0;
         run_eight <= 1'b0;
         first_12_pending <= 1'b1;
      end else begin
         // Switching 8 to 12 bit re-arms the long first conversion; taken from the
         // mode write itself so that a start in the very next cycle already sees it
         if (wr_mode && resolution_select && !reg_wdata[`AMRTC_MODE_RESOLUTION_SELECT]) begin
            first_12_pending <= 1'b1;
         end
         case (state)
            ST_IDLE: begin
               if (start_wr) begin
                  state <= ST_RUN;
                  count <= length;
                  conv_busy <= 1'b1;
                  run_cmp <= cmp_now;
                  run_eight <= resolution_select;
                  if (!cmp_now && !resolution_select) begin
                     first_12_pending <= 1'b0;
                  end
               end
            end
            ST_RUN: begin
               if (stop_wr || finish) begin
                  state <= ST_IDLE;
                  conv_busy <= 1'b0;
                  count <= {CNT_W{1'b0}};
               end else begin
                  count <= count - {{(CNT_W-1){1'b0}}, 1'b1};
               end
            end
            default: begin
               state <= ST_IDLE;
               conv_busy <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Software registers and result placement
   // ----------------------------------------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         input_channel_select <= 4'h0;
         comparator_select <= 1'b0;
         done_irq_enable <= 1'b0;
         conversion_done_flag <= 1'b0;
         offset_comp_ctrl <= 1'b0;
         conv_mode_reg <= `AMRTC_RST_MODE;
         result_low_reg <= `AMRTC_RST_RLOW;
         result_high_reg <= `AMRTC_RST_RHIGH;
      end else begin
         if (wr_ctrl) begin
            input_channel_select <= reg_wdata[`AMRTC_CTRL_CHAN_HI:`AMRTC_CTRL_CHAN_LO];
            comparator_select <= reg_wdata[`AMRTC_CTRL_CMP];
            done_irq_enable <= reg_wdata[`AMRTC_CTRL_IRQEN];
         end
         // Set wins over a clearing write in the same cycle
         if (finish) begin
            conversion_done_flag <= 1'b1;
         end else if (wr_ctrl) begin
            conversion_done_flag <= reg_wdata[`AMRTC_CTRL_DONE];
         end
         if (wr_mode) begin
            conv_mode_reg <= reg_wdata & `AMRTC_MODE_MASK;
            offset_comp_ctrl <= reg_wdata[`AMRTC_MODE_ADJ];
         end
         // Plain storage; a write lands except in the bits that a result places in the same cycle
         if (wr_low) begin
            result_low_reg <= reg_wdata & `AMRTC_RLOW_MASK;
         end
         if (wr_high) begin
            result_high_reg <= reg_wdata;
         end
         if (finish) begin
            if (run_cmp) begin
               result_low_reg[`AMRTC_RLOW_CMPRES] <= cmp_ref_below;
            end else if (run_eight) begin
               result_high_reg <= conv_value[RES_W-1:RES_W-8];
            end else begin
               result_high_reg <= conv_value[RES_W-1:RES_W-8];
               result_low_reg[7:4] <= conv_value[RES_W-9:RES_W-12];
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Read port, data one cycle after the strobe
   // ----------------------------------------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `AMRTC_OFF_CTRL: reg_rdata <= {input_channel_select, comparator_select, conv_busy,
                                          conversion_done_flag, done_irq_enable};
            `AMRTC_OFF_MODE: reg_rdata <= conv_mode_reg;
            `AMRTC_OFF_RLOW: reg_rdata <= result_low_reg;
            `AMRTC_OFF_RHIGH: reg_rdata <= result_high_reg;
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule
`default_nettype wire

// ==== amrtc_ctrl_properties.sv ====
// Port-level assertions for the converter control block
`default_nettype none
`include "amrtc_defs.vh"
module amrtc_ctrl_properties #(
   parameter RES_W = 12
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Front end and interrupt
   input wire logic [RES_W-1:0] conv_value,
   input wire logic cmp_ref_below,
   input wire logic [3:0] input_channel_select,
   input wire logic comparator_select,
   input wire logic offset_comp_ctrl,
   input wire logic conv_busy,
   input wire logic done_irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ------------------------------------------------
   // Run length counter
   // ------------------------------------------------
   logic [15:0] run;
   wire ctl_wr = reg_wr && reg_addr == `AMRTC_OFF_CTRL;
   always @(posedge clk) begin
      run <= (sys_rst || !conv_busy) ? 16'h0000 : run + 16'h0001;
   end
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data outside slot");
   start_run_a: assert property (ctl_wr && reg_wdata[2] && !conv_busy |=> conv_busy) else $error("no start");
   abort_run_a: assert property (ctl_wr && reg_wdata[2:1] == 2'b00 && conv_busy
      |=> !conv_busy && !done_irq) else $error("abort failed");
   ctrl_fields_a: assert property (ctl_wr
      |=> {input_channel_select, comparator_select} == $past(reg_wdata[7:3])) else $error("control fields wrong");
   ctrl_readback_a: assert property (reg_rd && reg_addr == `AMRTC_OFF_CTRL
      |=> reg_rdata[2] == $past(conv_busy) && (reg_rdata[1] & reg_rdata[0]) == $past(done_irq))
      else $error("control readback wrong");
   done_cause_a: assert property ($rose(done_irq) |-> $past(reg_wr) || $fell(conv_busy)) else $error("stray irq");
   done_sticky_a: assert property ($fell(done_irq) |-> $past(ctl_wr)) else $error("done flag lost");
   run_floor_a: assert property ($fell(conv_busy) && !$past(reg_wr) |-> $past(run) >= 16'h001c)
      else $error("run too short");
   run_ceiling_a: assert property (run <= 16'h3404) else $error("run too long");
   unmapped_read_a: assert property (reg_rd && (reg_addr < `AMRTC_OFF_CTRL || reg_addr > `AMRTC_OFF_RHIGH)
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   cover property ($rose(conv_busy));
   cover property ($rose(done_irq));
   cover property (ctl_wr && !reg_wdata[2] && conv_busy);
endmodule
`default_nettype wire

// ==== amrtc_ctrl_tb.sv ====
// Self-checking bench for the converter control block
`default_nettype none
`include "amrtc_defs.vh"
module amrtc_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] ctl = `AMRTC_OFF_CTRL;
   localparam logic [15:0] mdr = `AMRTC_OFF_MODE;
   localparam logic [15:0] rlo = `AMRTC_OFF_RLOW;
   localparam logic [15:0] rhi = `AMRTC_OFF_RHIGH;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [11:0] conv_value = 12'h000;
   logic cmp_ref_below = 1'b0;
   logic [7:0] reg_rdata;
   logic [3:0] input_channel_select;
   logic comparator_select, offset_comp_ctrl, conv_busy, done_irq;
   int error_cnt = 0;
   int checks = 0;
   int n;
   logic [31:0] seed = 32'he088c1c0;
   always #2.5 clk = ~clk;
   amrtc_ctrl amrtc_ctrl_inst (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_value(conv_value),
      .cmp_ref_below(cmp_ref_below), .input_channel_select(input_channel_select),
      .comparator_select(comparator_select), .offset_comp_ctrl(offset_comp_ctrl), .conv_busy(conv_busy),
      .done_irq(done_irq));
   // ------------------------------------------------
   // Helpers
   // ------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Doubling applies to the whole run, tail included
   function automatic int exp_len(input int base, input int code, input bit dbl);
      return ((base << code) + 2) * (dbl ? 2 : 1);
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk({8'h00, reg_rdata}, {8'h00, e});
   endtask
   // Counts edges from the start write to the fall of busy
   task automatic run(input logic [7:0] c, input int e);
      wr(ctl, c);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (conv_busy === 1'b1 && n < 30000);
      chk(n[15:0], e[15:0]);
      chk({15'h0000, done_irq}, 16'h0001);
   endtask
   task automatic wrap_up;
      if (error_cnt == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      // Runs add up to about 43k cycles; 60k cycles is the limit
      #300000;
      error_cnt++;
      wrap_up;
   end
   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 4; i++) rd(ctl + 16'(i), 8'h00);
      wr(16'h7f24, 8'hff);
      rd(16'h7f24, 8'h00);
      rd(16'h7f1f, 8'h00);
      repeat (4) begin
         seed = lfsr(seed);
         wr(rhi, seed[7:0]);
         wr(rlo, seed[15:8]);
         wr(mdr, seed[23:16]);
         rd(rhi, seed[7:0]);
         rd(rlo, seed[15:8] & `AMRTC_RLOW_MASK);
         rd(mdr, seed[23:16] & `AMRTC_MODE_MASK);
      end
      wr(mdr, 8'h00);
      wr(rlo, 8'h00);
      conv_value <= seed[27:16];
      run(8'h05, exp_len(52, 0, 1));
      run(8'h05, exp_len(52, 0, 0));
      rd(rhi, conv_value[11:4]);
      rd(rlo, {conv_value[3:0], 4'h0});
      wr(ctl, 8'h01);
      #1;
      chk({15'h0000, done_irq}, 16'h0000);
      for (int k = 0; k < 8; k++) begin
         seed = lfsr(seed);
         conv_value <= seed[11:0];
         cmp_ref_below <= seed[12];
         wr(rlo, {seed[19:16], 3'b000, k[2]});
         wr(mdr, {6'h10, k[1:0]});
         run({4'(k + 3), 4'h5}, exp_len(32, k, 0));
         chk({12'h000, input_channel_select}, 16'(k + 3));
         rd(rlo, {seed[19:16], 3'b000, k[2]});
         rd(rhi, conv_value[11:4]);
         wr(mdr, {6'h00, k[1:0]});
         run({4'(k + 3), 4'h5}, exp_len(52, k, 1));
         rd(rlo, {conv_value[3:0], 3'b000, k[2]});
         wr(rhi, seed[31:24]);
         wr(mdr, {6'h01, k[1:0]});
         run({4'(k + 3), 4'hd}, exp_len(28, k, 0));
         chk({14'h0000, comparator_select, offset_comp_ctrl}, 16'h0003);
         rd(rlo, {cmp_ref_below, conv_value[2:0], 3'b000, k[2]});
         rd(rhi, seed[31:24]);
      end
      wr(mdr, 8'h03);
      wr(rlo, 8'h01);
      wr(ctl, 8'h05);
      repeat (20) @(posedge clk);
      wr(ctl, 8'h01);
      #1;
      chk({14'h0000, conv_busy, done_irq}, 16'h0000);
      wr(ctl, 8'h05);
      repeat (20) @(posedge clk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      rd(ctl, 8'h00);
      run(8'h05, exp_len(52, 0, 1));
      wrap_up;
   end
endmodule
bind amrtc_ctrl amrtc_ctrl_properties #(.RES_W(RES_W)) amrtc_ctrl_properties_inst (.clk(clk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .conv_value(conv_value), .cmp_ref_below(cmp_ref_below), .input_channel_select(input_channel_select),
   .comparator_select(comparator_select), .offset_comp_ctrl(offset_comp_ctrl), .conv_busy(conv_busy),
   .done_irq(done_irq));
`default_nettype wire
